// [rtl/pixel_mix_compare_unit.sv]
// per-pixel mix, compare and write-protect datapath with operation control
`timescale 1ns/1ps
module pixel_mix_compare_unit import pixel_mix_pkg::*; #(
    parameter int COUNT_W = 24
) (
    input wire logic clk,
    input wire logic rst,
    input wire mixConfig_type cfg, // mix, colour and mask settings
    input wire logic opStart, // pulse: top byte of pixel operation written
    input wire logic [COUNT_W-1:0] opPixels, // pixels in the operation, at least one
    input wire logic suspendReq, // level: hold the running operation
    input wire logic terminateReq, // pulse: abort the operation
    input wire logic completeClear, // pulse: software writes one to status
    input wire logic completeIntEnable, // level: interrupt on completion
    input wire logic pixelValid, // fetched pixel present
    input wire pixelIn_type pixelIn,
    output logic pixelReady, // pixel accepted this cycle when valid
    output pixelOut_type pixelOut, // registered write-back, one cycle per pixel
    output logic busy,
    output logic auxBusy, // mirror of busy
    output logic completeStatus,
    output logic completeIrq
);

    if (COUNT_W < 1 || COUNT_W > 32) begin : gCheck
        $error("COUNT_W must be 1 to 32");
    end

    // whole state of the unit
    typedef struct packed {
        opState_type st;
        logic [COUNT_W-1:0] remain;
        logic ready;
        pixelOut_type out;
        logic busy;
        logic status;
        logic irq;
    } unitState_type;

    // fieldwise addition result
    typedef struct packed {
        logic [PIX_W-1:0] sum;
        logic [PIX_W-1:0] fieldCarry; // carry out of the field each bit sits in
    } fieldSum_type;

    unitState_type s_q, s_d;

    // bits per pixel from size code
    function automatic logic [4:0] pixWidth(input logic [2:0] code);
        logic [4:0] w;
        w = 5'h01;
        if (code <= SIZE_MAX_CODE) begin
            w = 5'(5'h01 << code);
        end
        return w;
    endfunction

    // field end marks: a field ends where the chain is broken or at the pixel top
    function automatic logic [PIX_W-1:0] fieldEnds(input logic [CHAIN_W-1:0] chain, input logic [4:0] w);
        logic [PIX_W-1:0] e;
        e = '0;
        for (int i = 0; i < PIX_W; i++) begin
            if (i == int'(w) - 1) begin
                e[i] = 1'b1; // carry out of the top bit ends here and becomes the top field's carry
            end else if (i < int'(w) - 1) begin
                e[i] = ~chain[i]; // mask bit gates carry upward
            end
            // bits above the pixel width need not be written
        end
        return e;
    endfunction

    // ripple add of a and b with carry-in at every field start
    function automatic fieldSum_type fieldAdd(input logic [PIX_W-1:0] a, input logic [PIX_W-1:0] b,
                                              input logic cin, input logic [PIX_W-1:0] ends);
        fieldSum_type r;
        logic c;
        logic [PIX_W-1:0] cout;
        logic fc;
        r = '0;
        cout = '0;
        c = cin;
        for (int i = 0; i < PIX_W; i++) begin
            r.sum[i] = a[i] ^ b[i] ^ c;
            cout[i] = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
            c = ends[i] ? cin : cout[i]; // no carry across a field boundary
        end
        // spread each field's carry out over the field's bits
        fc = 1'b0;
        for (int i = PIX_W - 1; i >= 0; i--) begin
            if (ends[i]) begin
                fc = cout[i];
            end
            r.fieldCarry[i] = fc;
        end
        return r;
    endfunction

    // unsigned compare for colour compare
    function automatic logic compareHit(input logic [2:0] cond, input logic [PIX_W-1:0] d,
                                        input logic [PIX_W-1:0] v);
        logic hit;
        unique case (cond)
            CMP_TRUE: hit = 1'b1;
            CMP_GT: hit = d > v;
            CMP_EQ: hit = d == v;
            CMP_LT: hit = d < v;
            CMP_FALSE: hit = 1'b0;
            CMP_GE: hit = d >= v;
            CMP_NE: hit = d != v;
            CMP_LE: hit = d <= v;
        endcase
        return hit;
    endfunction

    // datapath signals
    logic [4:0] width;
    logic [PIX_W-1:0] widthMask; // bits inside the pixel
    logic [PIX_W-1:0] wrMask; // effective write-protect mask
    logic [PIX_W-1:0] ends;
    logic [PIX_W-1:0] srcM, dstM; // operands with protected bits removed
    logic pattern;
    logic [PIX_W-1:0] opSrc;
    logic [7:0] mix;
    fieldSum_type addR, dmsR, smdR;
    logic [PIX_W-1:0] mixed;
    logic [PIX_W-1:0] halfSum; // field sum moved down one bit for the average
    logic cmpTrue;
    logic doWrite;
    logic accept;

    // pattern, source select, mix and compare
    always_comb begin
        width = pixWidth(cfg.sizeCode);
        widthMask = 16'hFFFF >> (5'h10 - width); // one-cycle pixel at any width
        wrMask = cfg.bitMask & widthMask; // only low mask bits count on narrow pixels
        ends = fieldEnds(cfg.chainMask, width);
        // protected bits take no part in arithmetic or compare
        srcM = pixelIn.src & wrMask;
        dstM = pixelIn.dst & wrMask;
        // pattern source
        unique case (cfg.patSel)
            PAT_MAP_A: pattern = pixelIn.patBits[0];
            PAT_MAP_B: pattern = pixelIn.patBits[1];
            PAT_MAP_C: pattern = pixelIn.patBits[2];
            PAT_ONE: pattern = 1'b1;
            PAT_FROM_SOURCE: pattern = |(pixelIn.src & widthMask); // map ignored
            default: pattern = 1'b1; // undefined select acts as fixed one
        endcase
        // foreground on pattern one, background on zero
        if (pattern) begin
            opSrc = cfg.fgFromMap ? pixelIn.src : cfg.fgColor; // fixed colours expand a 1-bit map
            mix = cfg.fgMix;
        end else begin
            opSrc = cfg.bgFromMap ? pixelIn.src : cfg.bgColor;
            mix = cfg.bgMix;
        end
        opSrc = opSrc & wrMask;
        // fieldwise adders shared by the arithmetic mixes
        // protected bits carry a one against a zero, so the carry runs through them untouched
        addR = fieldAdd(opSrc | ~wrMask, dstM, 1'b0, ends);
        dmsR = fieldAdd(dstM, ~opSrc, 1'b1, ends);
        smdR = fieldAdd(opSrc, ~dstM, 1'b1, ends);
        halfSum = {1'b0, addR.sum[PIX_W-1:1]};
        mixed = '0;
        for (int i = 0; i < PIX_W; i++) begin
            if (mix <= MIX_LOGIC_LAST) begin
                mixed[i] = mix[{~opSrc[i], ~dstM[i]}]; // truth table indexed by operands
            end else begin
                unique case (mix)
                    MIX_MAX: mixed[i] = dmsR.fieldCarry[i] ? dstM[i] : opSrc[i]; // no borrow: dst >= src
                    MIX_MIN: mixed[i] = dmsR.fieldCarry[i] ? opSrc[i] : dstM[i];
                    MIX_ADD_SAT: mixed[i] = addR.fieldCarry[i] | addR.sum[i]; // overflow clamps high
                    MIX_DMS_SAT: mixed[i] = dmsR.fieldCarry[i] & dmsR.sum[i]; // borrow clamps to zero
                    MIX_SMD_SAT: mixed[i] = smdR.fieldCarry[i] & smdR.sum[i];
                    MIX_AVERAGE: begin
                        // halve the field sum, field top takes the carry
                        if (ends[i] || i == PIX_W - 1) begin
                            mixed[i] = addR.fieldCarry[i];
                        end else begin
                            mixed[i] = halfSum[i];
                        end
                    end
                    default: mixed[i] = pixelIn.dst[i]; // reserved codes keep destination
                endcase
            end
        end
        mixed = mixed & widthMask;
        cmpTrue = compareHit(cfg.cmpCond, dstM, cfg.cmpValue & wrMask);
        // compare true or mask pixel zero blocks the update
        doWrite = ~cmpTrue & ~(cfg.maskEnable & ~pixelIn.maskBit);
        accept = s_q.ready & pixelValid;
    end

    // operation control and output staging
    always_comb begin
        s_d = s_q;
        s_d.out.write = 1'b0;
        if (accept) begin
            // protected bits keep the old destination value
            s_d.out.data = (mixed & wrMask) | (pixelIn.dst & ~wrMask);
            s_d.out.bitEnable = doWrite ? wrMask : '0;
            s_d.out.write = doWrite;
        end
        unique case (s_q.st)
            ST_IDLE: begin
                // start on top byte write; a zero count runs one pixel
                if (opStart && !terminateReq) begin
                    s_d.st = ST_RUN;
                    s_d.remain = (opPixels == '0) ? COUNT_W'(1) : opPixels;
                end
            end
            ST_RUN: begin
                if (terminateReq) begin
                    s_d.st = ST_IDLE; // abort, no completion
                end else if (accept && s_q.remain == COUNT_W'(1)) begin
                    s_d.st = ST_IDLE;
                    s_d.status = 1'b1; // set on every completion
                end else begin
                    if (accept) begin
                        s_d.remain = s_q.remain - COUNT_W'(1);
                    end
                    if (suspendReq) begin
                        s_d.st = ST_SUSPEND; // the pixel in flight finishes first
                    end
                end
            end
            ST_SUSPEND: begin
                // new start is ignored until terminate clears the held operation
                if (terminateReq) begin
                    s_d.st = ST_IDLE;
                end else if (!suspendReq) begin
                    s_d.st = ST_RUN; // release resumes
                end
            end
            default: s_d.st = ST_IDLE; // illegal code recovers to idle
        endcase
        // clear by writing one; a completion in the same cycle wins
        if (completeClear && !(s_q.st == ST_RUN && s_d.st == ST_IDLE && s_d.status && !terminateReq)) begin
            s_d.status = 1'b0;
        end
        s_d.irq = s_d.status & completeIntEnable;
        s_d.busy = (s_d.st != ST_IDLE); // suspended still counts as busy
        s_d.ready = (s_d.st == ST_RUN) && !suspendReq && !terminateReq;
        if (s_q.st == ST_RUN && accept && s_q.remain == COUNT_W'(1)) begin
            s_d.ready = 1'b0; // last pixel taken, stop accepting
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{st: ST_IDLE, remain: '0, ready: 1'b0, out: '0, busy: 1'b0, status: 1'b0, irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs come straight from the state register
    assign pixelReady = s_q.ready;
    assign pixelOut = s_q.out;
    assign busy = s_q.busy;
    assign auxBusy = s_q.busy;
    assign completeStatus = s_q.status;
    assign completeIrq = s_q.irq;

endmodule

// [rtl/pixel_mix_pkg.sv]
// package with constants, types and encodings for the pixel mix and compare unit
// Functional notes
// - mix codes 00..0F give all Boolean functions
// - mix codes 10..15 give max, min, saturating arithmetic, average
// - saturating results clamp to all ones or zero
// - carry mask gates carry to next bit
// - mask bits above pixel width are ignored
// - pattern from map A, B, C, one, or source
// - source-generated pattern is one when source nonzero
// - colour expansion uses foreground and background colours
// - write-protected bits keep value, excluded from arithmetic
// - narrow pixels use only low write-mask bits
// - compare condition decodes eight relations against value
// - true compare condition suppresses pixel write
// - start on pixel operation top byte write
// - suspend halts operation, release resumes it
// - terminate aborts running operation
// - completion always sets complete status bit
// - writing one clears complete status bit
// - enabled completion also raises interrupt request
// - busy and auxiliary busy read one while running
// - pattern one picks foreground source and mix
// - mask pixel zero leaves destination unmodified
package pixel_mix_pkg;
    localparam int PIX_W = 16; // widest pixel
    localparam int CHAIN_W = PIX_W - 1; // carry chain mask width
    // mix codes
    localparam logic [7:0] MIX_LOGIC_LAST = 8'h0F;
    localparam logic [7:0] MIX_MAX = 8'h10;
    localparam logic [7:0] MIX_MIN = 8'h11;
    localparam logic [7:0] MIX_ADD_SAT = 8'h12;
    localparam logic [7:0] MIX_DMS_SAT = 8'h13;
    localparam logic [7:0] MIX_SMD_SAT = 8'h14;
    localparam logic [7:0] MIX_AVERAGE = 8'h15;
    // compare conditions
    localparam logic [2:0] CMP_TRUE = 3'h0;
    localparam logic [2:0] CMP_GT = 3'h1;
    localparam logic [2:0] CMP_EQ = 3'h2;
    localparam logic [2:0] CMP_LT = 3'h3;
    localparam logic [2:0] CMP_FALSE = 3'h4;
    localparam logic [2:0] CMP_GE = 3'h5;
    localparam logic [2:0] CMP_NE = 3'h6;
    localparam logic [2:0] CMP_LE = 3'h7;
    // pixel size codes, log2 of bits per pixel
    localparam logic [2:0] SIZE_MAX_CODE = 3'h4;
    // pattern source choice
    typedef enum logic [2:0] {
        PAT_MAP_A = 3'b000,
        PAT_MAP_B = 3'b001,
        PAT_MAP_C = 3'b010,
        PAT_ONE = 3'b011,
        PAT_FROM_SOURCE = 3'b100
    } patSel_type;
    // operation control state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_SUSPEND = 2'b10
    } opState_type;
    // static configuration held by the register file outside
    typedef struct packed {
        logic [7:0] fgMix;
        logic [7:0] bgMix;
        logic [2:0] cmpCond;
        logic [PIX_W-1:0] cmpValue;
        logic [PIX_W-1:0] bitMask;
        logic [CHAIN_W-1:0] chainMask;
        logic [PIX_W-1:0] fgColor;
        logic [PIX_W-1:0] bgColor;
        logic [2:0] sizeCode;
        patSel_type patSel;
        logic fgFromMap;
        logic bgFromMap;
        logic maskEnable;
    } mixConfig_type;
    // one pixel of fetched map data
    typedef struct packed {
        logic [PIX_W-1:0] src;
        logic [PIX_W-1:0] dst;
        logic [2:0] patBits;
        logic maskBit;
    } pixelIn_type;
    // one pixel of write-back data
    typedef struct packed {
        logic [PIX_W-1:0] data;
        logic [PIX_W-1:0] bitEnable;
        logic write;
    } pixelOut_type;
endpackage

// [testbench/pixel_mix_compare_unit_props.sv]
// port checker for the pixel mix and compare unit
`timescale 1ns/1ps
module pixel_mix_compare_unit_props import pixel_mix_pkg::*; #(
    parameter int COUNT_W = 24
) (
    input wire logic clk,
    input wire logic rst,
    input wire mixConfig_type cfg,
    input wire logic opStart,
    input wire logic [COUNT_W-1:0] opPixels,
    input wire logic suspendReq,
    input wire logic terminateReq,
    input wire logic completeClear,
    input wire logic completeIntEnable,
    input wire logic pixelValid,
    input wire pixelIn_type pixelIn,
    input wire logic pixelReady,
    input wire pixelOut_type pixelOut,
    input wire logic busy,
    input wire logic auxBusy,
    input wire logic completeStatus,
    input wire logic completeIrq
);
    // one clock domain, reset is synchronous
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a start that the idle unit must take
    sequence startTaken;
        opStart && !busy && !terminateReq && !suspendReq;
    endsequence
    // a run that ends without being aborted
    sequence runEnds;
        busy && !terminateReq ##1 !busy;
    endsequence
    a_start_raises_busy: assert property (startTaken |=> busy && pixelReady)
        else $error("start did not raise busy");
    a_aux_busy_mirror: assert property (auxBusy == busy)
        else $error("aux busy differs from busy");
    a_idle_not_ready: assert property (!busy |-> !pixelReady)
        else $error("ready while idle");
    a_terminate_ends_run: assert property (busy && terminateReq |=> !busy && !pixelReady)
        else $error("terminate did not abort");
    a_suspend_holds_run: assert property (busy && suspendReq && !terminateReq && !pixelValid |=> busy && !pixelReady)
        else $error("suspend did not hold");
    a_end_sets_status: assert property (runEnds |-> completeStatus)
        else $error("completion without status");
    a_clear_drops_status: assert property (completeClear && !busy |=> !completeStatus)
        else $error("status not cleared");
    a_irq_follows_status: assert property (completeIrq == (completeStatus && $past(completeIntEnable)))
        else $error("interrupt request wrong");
    a_write_needs_pixel: assert property (pixelOut.write |-> $past(pixelValid && pixelReady))
        else $error("write without accepted pixel");
    a_cmp_true_blocks: assert property ($past(pixelValid && pixelReady && cfg.cmpCond == CMP_TRUE) |-> !pixelOut.write)
        else $error("write despite true compare");
    a_mask_zero_blocks: assert property ($past(pixelValid && pixelReady && cfg.maskEnable && !pixelIn.maskBit)
        |-> !pixelOut.write)
        else $error("write despite mask zero");
endmodule
bind pixel_mix_compare_unit pixel_mix_compare_unit_props #(.COUNT_W(COUNT_W)) props (.clk(clk), .rst(rst),
    .cfg(cfg), .opStart(opStart), .opPixels(opPixels), .suspendReq(suspendReq), .terminateReq(terminateReq),
    .completeClear(completeClear), .completeIntEnable(completeIntEnable), .pixelValid(pixelValid),
    .pixelIn(pixelIn), .pixelReady(pixelReady), .pixelOut(pixelOut), .busy(busy), .auxBusy(auxBusy),
    .completeStatus(completeStatus), .completeIrq(completeIrq));

// [testbench/testbench.sv]
// self-checking bench for the pixel mix and compare unit
`timescale 1ns/1ps
module testbench;
    import pixel_mix_pkg::*;
    logic clk, rst, opStart, suspendReq, terminateReq, completeClear, completeIntEnable, pixelValid;
    logic pixelReady, busy, auxBusy, completeStatus, completeIrq;
    logic [23:0] opPixels; // pixels per operation
    mixConfig_type cfg;
    pixelIn_type pixelIn;
    pixelOut_type pixelOut;
    int failures, checksDone;
    // one table row: settings, pixel, expected write-back
    typedef struct packed {
        logic [7:0] fg, bg;
        logic [2:0] cond, size, ps, pb;
        logic [15:0] bm;
        logic me, mb;
        logic [15:0] src, dst, ed;
        logic ew;
    } row_type;
    row_type rows[19];
    row_type r;
    pixel_mix_compare_unit #(.COUNT_W(24)) dut (.clk(clk), .rst(rst), .cfg(cfg), .opStart(opStart),
        .opPixels(opPixels), .suspendReq(suspendReq), .terminateReq(terminateReq), .completeClear(completeClear),
        .completeIntEnable(completeIntEnable), .pixelValid(pixelValid), .pixelIn(pixelIn), .pixelReady(pixelReady),
        .pixelOut(pixelOut), .busy(busy), .auxBusy(auxBusy), .completeStatus(completeStatus), .completeIrq(completeIrq));
    // free running clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // verdict and end of run, shared with the watchdog
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk1(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // the sixteen boolean mixes written out one by one
    function automatic logic [15:0] logicMix(input logic [3:0] c, input logic [15:0] s, input logic [15:0] d);
        case (c)
            4'h0: logicMix = 16'h0000;
            4'h1: logicMix = s & d;
            4'h2: logicMix = s & ~d;
            4'h3: logicMix = s;
            4'h4: logicMix = ~s & d;
            4'h5: logicMix = d;
            4'h6: logicMix = s ^ d;
            4'h7: logicMix = s | d;
            4'h8: logicMix = ~s & ~d;
            4'h9: logicMix = s ^ ~d;
            4'hA: logicMix = ~d;
            4'hB: logicMix = s | ~d;
            4'hC: logicMix = ~s;
            4'hD: logicMix = ~s | d;
            4'hE: logicMix = ~s | ~d;
            default: logicMix = 16'hFFFF;
        endcase
    endfunction
    // compare condition against the compare value
    function automatic logic cmpHolds(input logic [2:0] c, input logic [15:0] d, input logic [15:0] v);
        case (c)
            3'h0: cmpHolds = 1'b1;
            3'h1: cmpHolds = d > v;
            3'h2: cmpHolds = d == v;
            3'h3: cmpHolds = d < v;
            3'h4: cmpHolds = 1'b0;
            3'h5: cmpHolds = d >= v;
            3'h6: cmpHolds = d != v;
            default: cmpHolds = d <= v;
        endcase
    endfunction
    // single-pixel operation; colour rows use pattern map B with fixed colours
    task automatic runOne(input row_type x);
        logic [15:0] wMask; // writable bits of the pixel at this size
        @(negedge clk);
        wMask = x.bm & (16'hFFFF >> (5'h10 - (5'h01 << x.size)));
        cfg.fgMix = x.fg;
        cfg.bgMix = x.bg;
        cfg.cmpCond = x.cond;
        cfg.sizeCode = x.size;
        cfg.bitMask = x.bm;
        cfg.patSel = patSel_type'(x.ps);
        cfg.fgFromMap = (x.ps != 3'h1);
        cfg.bgFromMap = (x.ps != 3'h1);
        cfg.maskEnable = x.me;
        cfg.chainMask = (x.size == 3'h3) ? 15'h7F77 : 15'h7FFF; // 8-bit pixels split at bit 3 into two 4-bit fields
        opStart = 1'b1;
        @(negedge clk);
        opStart = 1'b0;
        chk1(busy, 1'b1);
        pixelValid = 1'b1;
        pixelIn = '{x.src, x.dst, x.pb, x.mb};
        @(negedge clk);
        pixelValid = 1'b0;
        chk1(pixelOut.write, x.ew);
        if (x.ew) chk16(pixelOut.data, x.ed);
        chk16(pixelOut.bitEnable, x.ew ? wMask : 16'h0000);
        chk1(busy, 1'b0);
        chk1(completeStatus, 1'b1);
        chk1(completeIrq, 1'b0);
        completeClear = 1'b1;
        @(negedge clk);
        completeClear = 1'b0;
        chk1(completeStatus, 1'b0);
    endtask
    // hang guard, runs far beyond the few hundred cycles needed
    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end
    initial begin
        {opStart, suspendReq, terminateReq, completeClear, completeIntEnable, pixelValid} = '0;
        opPixels = 24'h000001;
        cfg = '0;
        cfg.cmpValue = 16'h0005;
        cfg.fgColor = 16'h00AA;
        cfg.bgColor = 16'h0055;
        pixelIn = '0;
        rows = '{
            '{8'h10, 8'h05, 3'h4, 3'h4, 3'h3, 3'h0, 16'hFFFF, 1'b0, 1'b0, 16'h1234, 16'h5678, 16'h5678, 1'b1},
            '{8'h11, 8'h05, 3'h4, 3'h4, 3'h3, 3'h0, 16'hFFFF, 1'b0, 1'b0, 16'h1234, 16'h5678, 16'h1234, 1'b1},
            '{8'h12, 8'h05, 3'h4, 3'h4, 3'h3, 3'h0, 16'hFFFF, 1'b0, 1'b0, 16'hC000, 16'h5000, 16'hFFFF, 1'b1},
            '{8'h13, 8'h05, 3'h4, 3'h4, 3'h3, 3'h0, 16'hFFFF, 1'b0, 1'b0, 16'h2000, 16'h1000, 16'h0000, 1'b1},
            '{8'h14, 8'h05, 3'h4, 3'h4, 3'h3, 3'h0, 16'hFFFF, 1'b0, 1'b0, 16'h2000, 16'h1000, 16'h1000, 1'b1},
            '{8'h15, 8'h05, 3'h4, 3'h4, 3'h3, 3'h0, 16'hFFFF, 1'b0, 1'b0, 16'h0003, 16'h0006, 16'h0004, 1'b1},
            '{8'h12, 8'h05, 3'h4, 3'h3, 3'h3, 3'h0, 16'hFFFF, 1'b0, 1'b0, 16'h001C, 16'h000A, 16'h001F, 1'b1},
            '{8'h0F, 8'h05, 3'h4, 3'h4, 3'h3, 3'h0, 16'h00F0, 1'b0, 1'b0, 16'h1234, 16'h1234, 16'h12F4, 1'b1},
            '{8'h0F, 8'h05, 3'h4, 3'h2, 3'h3, 3'h0, 16'hFFF3, 1'b0, 1'b0, 16'h1234, 16'h0000, 16'h0003, 1'b1},
            '{8'h03, 8'h05, 3'h2, 3'h4, 3'h3, 3'h0, 16'h00FF, 1'b0, 1'b0, 16'h0000, 16'h0105, 16'h0000, 1'b0},
            '{8'h0F, 8'h05, 3'h4, 3'h4, 3'h4, 3'h7, 16'hFFFF, 1'b0, 1'b0, 16'h0000, 16'h1111, 16'h1111, 1'b1},
            '{8'h0F, 8'h05, 3'h4, 3'h4, 3'h4, 3'h0, 16'hFFFF, 1'b0, 1'b0, 16'h0001, 16'h1111, 16'hFFFF, 1'b1},
            '{8'h03, 8'h03, 3'h4, 3'h3, 3'h1, 3'h2, 16'hFFFF, 1'b0, 1'b0, 16'h1234, 16'h0000, 16'h00AA, 1'b1},
            '{8'h03, 8'h03, 3'h4, 3'h3, 3'h1, 3'h5, 16'hFFFF, 1'b0, 1'b0, 16'h1234, 16'h0000, 16'h0055, 1'b1},
            '{8'h0F, 8'h05, 3'h4, 3'h4, 3'h0, 3'h6, 16'hFFFF, 1'b0, 1'b0, 16'h1234, 16'h5678, 16'h5678, 1'b1},
            '{8'h0F, 8'h05, 3'h4, 3'h4, 3'h2, 3'h4, 16'hFFFF, 1'b0, 1'b0, 16'h1234, 16'h5678, 16'hFFFF, 1'b1},
            '{8'h0F, 8'h05, 3'h4, 3'h1, 3'h3, 3'h0, 16'hFFFF, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0003, 1'b1},
            '{8'h0F, 8'h05, 3'h4, 3'h0, 3'h3, 3'h0, 16'hFFFF, 1'b1, 1'b1, 16'h0000, 16'h0000, 16'h0001, 1'b1},
            '{8'h0F, 8'h05, 3'h4, 3'h4, 3'h3, 3'h0, 16'hFFFF, 1'b1, 1'b0, 16'h1234, 16'h5678, 16'h0000, 1'b0}};
        // reset for six cycles, all outputs quiet afterwards
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk1(busy | pixelReady | completeStatus | completeIrq | pixelOut.write, 1'b0);
        foreach (rows[i]) runOne(rows[i]);
        // every boolean mix code
        r = rows[0];
        for (int c = 0; c < 16; c++) begin
            r.fg = 8'(c); // only defined codes are driven, never 16..FF
            r.ed = logicMix(4'(c), r.src, r.dst);
            runOne(r);
        end
        // every compare condition below, at and above the compare value
        r.fg = 8'h03;
        for (int c = 0; c < 24; c++) begin
            r.cond = 3'(c / 3);
            r.dst = 16'h0004 + 16'(c % 3);
            r.ed = r.src;
            r.ew = !cmpHolds(r.cond, r.dst, 16'h0005);
            runOne(r);
        end
        // three-pixel run: suspend, refused restart, interrupt on completion
        completeIntEnable = 1'b1;
        cfg.cmpCond = CMP_FALSE;
        opStart = 1'b1;
        opPixels = 24'h000003;
        @(negedge clk);
        opPixels = 24'h000001; // start held while running is ignored, in the same cycle as the suspend request
        suspendReq = 1'b1;
        @(negedge clk);
        opStart = 1'b0;
        pixelValid = 1'b1;
        @(negedge clk);
        chk1(pixelReady, 1'b0);
        chk1(auxBusy, 1'b1);
        chk1(pixelOut.write, 1'b0);
        suspendReq = 1'b0;
        pixelValid = 1'b0;
        @(negedge clk);
        chk1(pixelReady, 1'b1);
        pixelValid = 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk1(busy, 1'b1);
        completeClear = 1'b1; // clear on the completing edge loses to the set
        @(negedge clk);
        completeClear = 1'b0;
        pixelValid = 1'b0;
        chk1(busy, 1'b0);
        chk1(completeStatus, 1'b1);
        @(negedge clk);
        chk1(completeIrq, 1'b1);
        completeClear = 1'b1;
        @(negedge clk);
        completeClear = 1'b0;
        chk1(completeIrq, 1'b0);
        completeIntEnable = 1'b0;
        // abort mid-run leaves no completion
        opStart = 1'b1;
        opPixels = 24'h000005;
        @(negedge clk);
        opStart = 1'b0;
        terminateReq = 1'b1;
        @(negedge clk);
        terminateReq = 1'b0;
        chk1(busy, 1'b0);
        chk1(completeStatus, 1'b0);
        // suspended run is terminated before the next start is given
        opStart = 1'b1;
        @(negedge clk);
        opStart = 1'b0;
        suspendReq = 1'b1;
        @(negedge clk);
        terminateReq = 1'b1;
        @(negedge clk);
        suspendReq = 1'b0;
        terminateReq = 1'b0;
        chk1(busy, 1'b0);
        opPixels = 24'h000001;
        runOne(rows[0]); // fresh start taken after terminate
        // reset in mid-run drops the unit back to idle
        opStart = 1'b1;
        @(negedge clk);
        opStart = 1'b0;
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk1(busy | pixelReady | completeStatus | completeIrq | pixelOut.write, 1'b0);
        tally_and_finish();
    end
endmodule
